// ### logic/sfowc_pkg.sv
// Constants for the serial port fault, overrun and wake control block
`default_nettype none
package sfowc_pkg;
   // Register byte offsets
   localparam logic [3:0] OFS_DATA = 4'h0;
   localparam logic [3:0] OFS_CTRL = 4'h4;
   localparam logic [3:0] OFS_CSR  = 4'h8;
   localparam logic [3:0] OFS_AUX  = 4'hC;
   // Control register fields
   localparam int CB_IE   = 7;
   localparam int CB_PE   = 6;
   localparam int CB_PRE  = 5;
   localparam int CB_CS   = 4;
   localparam int CB_CPOL = 3;
   localparam int CB_CPHA = 2;
   localparam int CB_RATE = 0;
   // Control/status register fields
   localparam int SB_DONE = 7;
   localparam int SB_WRITE_COLLIDE_FLAG = 6;
   localparam int SB_OVR  = 5;
   localparam int SB_MODE_FAULT_FLAG = 4;
   localparam int SB_SOD  = 2;
   localparam int SB_SSM  = 1;
   localparam int SB_SSI  = 0;
   localparam int CFG_W   = 3;
   // Reset values
   localparam logic [7:0]       CTRL_RST = 8'h00;
   localparam logic [CFG_W-1:0] CFG_RST  = 3'h0;
   // Timing counts
   localparam logic [3:0] BITS_PER_XFER = 4'h8;
   localparam logic [5:0] MIN_HALF      = 6'h02;
   typedef enum logic {ST_IDLE, ST_XFER} sfowc_state_e;
endpackage
`default_nettype wire

// ### logic/sfowc_top.sv
// Serial port with fault, overrun, collision, interrupt and halt wake logic
`timescale 1ns/1ns
`default_nettype none
module sfowc_top
   import sfowc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Serial pins
   input  wire logic        sck_i,
   output logic             sck_o,
   output logic             sck_oe,
   input  wire logic        mosi_i,
   output logic             mosi_o,
   output logic             mosi_oe,
   input  wire logic        miso_i,
   output logic             miso_o,
   output logic             miso_oe,
   input  wire logic        ss_n_i,
   // Power modes and interrupt
   input  wire logic        halt_mode,
   input  wire logic        cpu_irq_mask,
   output logic             irq_req,
   output logic             wake_req
);
   logic [7:0]       ctl_q;
   logic [CFG_W-1:0] cfg_q;
   logic             done_q, write_collide_flag_q, ovr_q, mode_fault_flag_q;
   logic             done_arm_q, write_collide_flag_arm_q, mode_fault_flag_arm_q;
   logic [7:0]       tx_sh_q, rx_sh_q, rx_buf_q, rdata_q;
   logic [3:0]       cnt_q;
   logic [5:0]       div_q;
   logic             sck_q, sck_in_q, rd_ack_q;
   logic             halt_q, wake_arm_q, recov_q;
   sfowc_state_e     st_q;

   logic       ie, pe, cs, cpol, cpha, sod, ss_low, run, fault;
   logic       wr_go, rd_go, wr_data, wr_ctl, wr_csr, rd_data, rd_csr;
   logic       busy, wr_block, t_chg, t_lead, t_trail, tick, c_lead, c_trail;
   logic       lead, trail, samp, shft, act, done_evt, ovr_evt, rx_bit;
   logic [3:0] nsamp;
   logic [5:0] half;
   logic [7:0] rx_byte, csr_val, ctl_w;

   assign ie   = ctl_q[CB_IE];
   assign pe   = ctl_q[CB_PE];
   assign cs   = ctl_q[CB_CS];
   assign cpol = ctl_q[CB_CPOL];
   assign cpha = ctl_q[CB_CPHA];
   assign sod  = cfg_q[SB_SOD];
   assign ss_low = cfg_q[SB_SSM] ? ~cfg_q[SB_SSI] : ~ss_n_i;
   // frozen in halt unless armed target
   assign run = ~halt_mode | (wake_arm_q & ~cs);
   assign fault = run & pe & cs & ss_low;

   // Bus decode; all accesses stall in halt, otherwise reads take one wait cycle, writes none
   assign avs_waitrequest = halt_mode | (avs_read & ~rd_ack_q);
   assign wr_go   = avs_write & ~halt_mode & avs_byteenable[0];
   assign rd_go   = avs_read & rd_ack_q & ~halt_mode;
   assign wr_data = wr_go & (avs_address == OFS_DATA);
   assign wr_ctl  = wr_go & (avs_address == OFS_CTRL);
   assign wr_csr  = wr_go & (avs_address == OFS_CSR);
   assign rd_data = rd_go & (avs_address == OFS_DATA);
   assign rd_csr  = rd_go & (avs_address == OFS_CSR);
   assign avs_readdata = {24'h000000, rdata_q};
   assign csr_val = {done_q, write_collide_flag_q, ovr_q, mode_fault_flag_q, 1'b0, cfg_q};

   // Serial clock edges, target from pin and controller from divider
   assign busy    = (st_q == ST_XFER);
   assign t_chg   = (sck_i != sck_in_q);
   assign t_lead  = t_chg & (sck_in_q == cpol);
   assign t_trail = t_chg & (sck_in_q != cpol);
   assign tick    = busy & (div_q == 6'h00);
   assign c_lead  = tick & (sck_q == cpol);
   assign c_trail = tick & (sck_q != cpol);
   assign act     = run & pe & (cs ? busy : (ss_low & (busy | t_lead)));
   assign lead    = act & (cs ? c_lead : t_lead);
   assign trail   = act & (cs ? c_trail : t_trail);
   assign samp    = cpha ? trail : lead;
   assign shft    = (cpha ? lead : trail) & (cnt_q != 4'h0);
   assign nsamp   = cnt_q + {3'h0, samp};
   assign rx_bit  = cs ? miso_i : mosi_i;
   assign rx_byte = {rx_sh_q[6:0], rx_bit};
   assign done_evt = ~fault & (nsamp == BITS_PER_XFER) & (cs ? c_trail & act : samp);
   // byte ends with done flag still set
   assign ovr_evt = done_evt & done_q;
   // prescale doubles the half period when clear
   assign half = (MIN_HALF << ctl_q[CB_RATE +: 2]) << {5'h00, ~ctl_q[CB_PRE]};
   assign wr_block = done_q & ~done_arm_q;

   // enable and select cannot be set while the fault flag is set and not yet armed by a status read
   always_comb begin
      ctl_w = avs_writedata[7:0];
      if (mode_fault_flag_q & ~mode_fault_flag_arm_q) begin
         ctl_w[CB_PE] = avs_writedata[CB_PE] & pe;
         ctl_w[CB_CS] = avs_writedata[CB_CS] & cs;
      end
   end

   // Read data and one-cycle read acknowledge
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rd_ack_q <= 1'b0;
         rdata_q  <= 8'h00;
      end else begin
         rd_ack_q <= avs_read & ~rd_ack_q & ~halt_mode;
         if (avs_read & ~rd_ack_q) begin
            unique case (avs_address)
               OFS_DATA: rdata_q <= rx_buf_q;
               OFS_CTRL: rdata_q <= ctl_q;
               OFS_CSR:  rdata_q <= csr_val;
               OFS_AUX:  rdata_q <= {7'h00, recov_q};
               default:  rdata_q <= 8'h00;
            endcase
         end
      end
   end

   // Control register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctl_q <= CTRL_RST;
      end else if (run) begin
         if (wr_ctl) begin
            ctl_q <= ctl_w;
         end
         if (fault) begin
            ctl_q[CB_PE] <= 1'b0;
            ctl_q[CB_CS] <= 1'b0;
         end
      end
   end

   // Software select and output disable configuration bits
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cfg_q <= CFG_RST;
      end else if (run & wr_csr) begin
         cfg_q <= avs_writedata[CFG_W-1:0];
      end
   end

   // Mode fault flag
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mode_fault_flag_q     <= 1'b0;
         mode_fault_flag_arm_q <= 1'b0;
      end else if (run) begin
         if (fault) begin
            mode_fault_flag_q <= 1'b1;
         // armed by status read, cleared by control write
         end else if (mode_fault_flag_arm_q & wr_ctl) begin
            mode_fault_flag_q <= 1'b0;
         end
         if (wr_ctl | ~mode_fault_flag_q) begin
            mode_fault_flag_arm_q <= 1'b0;
         end else if (rd_csr) begin
            mode_fault_flag_arm_q <= 1'b1;
         end
      end
   end

   // Transfer done flag
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         done_q     <= 1'b0;
         done_arm_q <= 1'b0;
      end else if (run) begin
         if (done_evt) begin
            done_q <= 1'b1;
         end else if (done_arm_q & (rd_data | wr_data)) begin
            done_q <= 1'b0;
         end
         if (~done_q | done_evt | (done_arm_q & (rd_data | wr_data))) begin
            done_arm_q <= 1'b0;
         end else if (rd_csr | wr_csr) begin
            done_arm_q <= 1'b1;
         end
      end
   end

   // Write collision and overrun flags
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         write_collide_flag_q     <= 1'b0;
         write_collide_flag_arm_q <= 1'b0;
         ovr_q      <= 1'b0;
      end else if (run) begin
         if (wr_data & busy) begin
            write_collide_flag_q <= 1'b1;
         end else if (write_collide_flag_arm_q & rd_data) begin
            write_collide_flag_q <= 1'b0;
         end
         if (~write_collide_flag_q | rd_data) begin
            write_collide_flag_arm_q <= 1'b0;
         end else if (rd_csr) begin
            write_collide_flag_arm_q <= 1'b1;
         end
         // set on overrun, status read clears
         if (ovr_evt) begin
            ovr_q <= 1'b1;
         end else if (rd_csr) begin
            ovr_q <= 1'b0;
         end
      end
   end

   // Receive buffer
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rx_buf_q <= 8'h00;
      // copy only when no byte is pending
      end else if (run & done_evt & ~done_q) begin
         rx_buf_q <= samp ? rx_byte : rx_sh_q;
      end
   end

   // Shift engine
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_q     <= ST_IDLE;
         cnt_q    <= 4'h0;
         div_q    <= 6'h00;
         sck_q    <= 1'b0;
         sck_in_q <= 1'b0;
         tx_sh_q  <= 8'h00;
         rx_sh_q  <= 8'h00;
      end else if (run) begin
         sck_in_q <= sck_i;
         if (samp) begin
            rx_sh_q <= rx_byte;
         end
         if (shft) begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
         end
         if (tick) begin
            div_q <= half - 6'h01;
            sck_q <= ~sck_q;
         end else if (busy) begin
            div_q <= div_q - 6'h01;
         end
         unique case (st_q)
            ST_IDLE: begin
               sck_q <= cpol;
               div_q <= half - 6'h01;
               cnt_q <= 4'h0;
               // accepted writes load only when idle
               if (wr_data & ~wr_block & pe) begin
                  tx_sh_q <= avs_writedata[7:0];
                  if (cs & ~fault) begin
                     st_q <= ST_XFER;
                  end
               end
               if (act & ~cs & t_lead) begin
                  st_q  <= ST_XFER;
                  cnt_q <= nsamp;
               end
            end
            ST_XFER: begin
               cnt_q <= nsamp;
               if (done_evt | fault | ~pe | (~cs & ~ss_low)) begin
                  st_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Halt entry capture and wake recovery
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         halt_q     <= 1'b0;
         wake_arm_q <= 1'b0;
         recov_q    <= 1'b0;
      end else begin
         halt_q <= halt_mode;
         // arm only if selected target at entry
         if (halt_mode & ~halt_q) begin
            wake_arm_q <= pe & ~cs & ss_low;
         end else if (~halt_mode) begin
            wake_arm_q <= 1'b0;
         end
         // recovery ends on leaving target or next byte
         if (~halt_mode & halt_q & wake_arm_q) begin
            recov_q <= 1'b1;
         end else if (cs | ~pe | done_evt) begin
            recov_q <= 1'b0;
         end
      end
   end

   // Pins driven only while the port is enabled
   assign sck_o   = sck_q;
   assign sck_oe  = pe & cs;
   assign mosi_o  = tx_sh_q[7];
   assign mosi_oe = pe & cs & ~sod;
   assign miso_o  = tx_sh_q[7];
   assign miso_oe = pe & ~cs & ~sod & ss_low;

   assign irq_req  = ie & ~cpu_irq_mask & (done_q | mode_fault_flag_q | ovr_q);
   assign wake_req = halt_mode ? (wake_arm_q & ie & ~cpu_irq_mask & done_q) : irq_req;

   chk_fault_drop: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      fault |=> !ctl_q[CB_PE] && !ctl_q[CB_CS] && mode_fault_flag_q)
      else $error("fault left port enabled");
   chk_target_nofault: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      !cs && !mode_fault_flag_q |=> !mode_fault_flag_q)
      else $error("target set fault flag");
   chk_enable_locked: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      mode_fault_flag_q && !mode_fault_flag_arm_q && !pe && wr_ctl && avs_writedata[CB_PE] |=> !ctl_q[CB_PE])
      else $error("enable set during fault");
   chk_fault_clear: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      mode_fault_flag_arm_q && wr_ctl && !fault |=> !mode_fault_flag_q)
      else $error("fault flag not cleared");
   chk_buffer_kept: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      ovr_evt |=> ovr_q && $stable(rx_buf_q))
      else $error("overrun replaced buffer");
   chk_write_collide: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      wr_data && busy && run |=> write_collide_flag_q && ($stable(tx_sh_q) || $past(shft)))
      else $error("collision not flagged");
   chk_irq_gate: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      irq_req |-> ie && !cpu_irq_mask && (done_q || mode_fault_flag_q || ovr_q))
      else $error("request without cause");
   chk_halt_frozen: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      halt_mode && !run ##1 halt_mode |-> $stable(ctl_q) && $stable(csr_val))
      else $error("registers changed in halt");
   chk_done_set: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      done_evt |=> done_q ##1 done_q)
      else $error("done flag not held");

endmodule // sfowc_top
`default_nettype wire

// ### sim/sfowc_peer.sv
// External serial controller model that clocks bytes into the target port
`timescale 1ns/1ns
`default_nettype none
module sfowc_peer (
   // Clock
   input  wire logic clk_sys,
   // Serial lines
   output logic      sck,
   output logic      mosi,
   output logic      ss_n,
   input  wire logic miso
);
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      ss_n = 1'b1;
   end
   task automatic select(input logic lvl);
      @(posedge clk_sys);
      ss_n <= lvl;
   endtask
   // Byte exchange, MSB first, sampled on rising clock
   task automatic send_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_sys);
         mosi <= tx[i];
         repeat (3) @(posedge clk_sys);
         @(negedge clk_sys);
         rx[i] = miso;
         @(posedge clk_sys);
         sck <= 1'b1;
         repeat (4) @(posedge clk_sys);
         sck <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      mosi <= ~mosi;
   endtask
endmodule // sfowc_peer
`default_nettype wire

// ### sim/sfowc_bench.sv
// Self-checking bench for the serial port fault, overrun and wake block
`timescale 1ns/1ns
`default_nettype none
module sfowc_bench;
   import sfowc_pkg::*;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic        cpu_irq_mask = 1'b0;
   logic        sck_o, mosi_o, mosi_oe;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        halt_mode = 1'b0;
   logic        irq_req, wake_req, sck, mosi, ss_n, miso_o, miso_oe, miso_line, sck_oe;
   int          err_count = 0;
   int          checks_done = 0;
   logic [7:0]  rx;
   logic [31:0] rd;

   always #5 clk_sys = ~clk_sys;
   assign miso_line = miso_oe ? miso_o : ~miso_o;

   sfowc_top i_sfowc_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .sck_i(sck), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
      .miso_i(mosi_o), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n), .halt_mode(halt_mode),
      .cpu_irq_mask(cpu_irq_mask), .irq_req(irq_req), .wake_req(wake_req));

   sfowc_peer i_sfowc_peer (.clk_sys(clk_sys), .sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso_line));

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= 1'b1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask

   task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask

   task automatic expect_reg(input string what, input logic [3:0] a, input logic [7:0] exp);
      bus_read(a, rd);
      check(what, {24'h000000, exp}, rd);
   endtask

   task automatic wait_irq;
      for (int n = 0; n < 400 && irq_req !== 1'b1; n++) @(posedge clk_sys);
   endtask

   task automatic t_reset_values;
      expect_reg("control", OFS_CTRL, CTRL_RST);
      expect_reg("status", OFS_CSR, 8'h00);
      expect_reg("unmapped", 4'h2, 8'h00);
      check("irq", 32'h0, {31'h0, irq_req});
   endtask

   task automatic t_mode_fault;
      bus_write(OFS_CSR, 8'h00);
      bus_write(OFS_CTRL, 8'hD0);
      expect_reg("control set", OFS_CTRL, 8'hD0);
   endtask

   task automatic t_fault;
      i_sfowc_peer.select(1'b0);
      repeat (4) @(posedge clk_sys);
      expect_reg("control after fault", OFS_CTRL, 8'h80);
      check("sck enable", 32'h0, {31'h0, sck_oe});
      check("irq fault", 32'h1, {31'h0, irq_req});
      i_sfowc_peer.select(1'b1);
      bus_write(OFS_CTRL, 8'hD0);
      expect_reg("control locked", OFS_CTRL, 8'h80);
      expect_reg("status fault", OFS_CSR, 8'h10);
      bus_write(OFS_CTRL, 8'hC0);
      expect_reg("control restored", OFS_CTRL, 8'hC0);
      expect_reg("status cleared", OFS_CSR, 8'h00);
      check("irq cleared", 32'h0, {31'h0, irq_req});
   endtask

   task automatic t_overrun;
      i_sfowc_peer.select(1'b0);
      i_sfowc_peer.send_byte(8'hA5, rx);
      wait_irq();
      check("irq done", 32'h1, {31'h0, irq_req});
      check("wake in wait", 32'h1, {31'h0, wake_req});
      cpu_irq_mask <= 1'b1;
      @(posedge clk_sys);
      check("irq masked", 32'h0, {31'h0, irq_req});
      cpu_irq_mask <= 1'b0;
      i_sfowc_peer.send_byte(8'h3C, rx);
      repeat (6) @(posedge clk_sys);
      expect_reg("status overrun", OFS_CSR, 8'hA0);
      expect_reg("kept byte", OFS_DATA, 8'hA5);
      expect_reg("status clear", OFS_CSR, 8'h00);
      check("irq idle", 32'h0, {31'h0, irq_req});
      i_sfowc_peer.select(1'b1);
   endtask

   task automatic t_collision;
      bus_write(OFS_DATA, 8'h96);
      i_sfowc_peer.select(1'b0);
      fork
         i_sfowc_peer.send_byte(8'h3C, rx);
         begin
            repeat (24) @(posedge clk_sys);
            bus_write(OFS_DATA, 8'h55);
            expect_reg("status collide", OFS_CSR, 8'h40);
            check("irq collide", 32'h0, {31'h0, irq_req});
         end
      join
      repeat (6) @(posedge clk_sys);
      i_sfowc_peer.select(1'b1);
      check("sent byte", 32'h96, {24'h0, rx});
      expect_reg("status done", OFS_CSR, 8'hC0);
      expect_reg("received", OFS_DATA, 8'h3C);
      expect_reg("status after", OFS_CSR, 8'h00);
   endtask

   task automatic t_halt;
      i_sfowc_peer.select(1'b0);
      @(posedge clk_sys);
      halt_mode <= 1'b1;
      i_sfowc_peer.send_byte(8'h11, rx);
      for (int n = 0; n < 400 && wake_req !== 1'b1; n++) @(posedge clk_sys);
      check("wake", 32'h1, {31'h0, wake_req});
      i_sfowc_peer.send_byte(8'h22, rx);
      @(posedge clk_sys);
      check("bus stalled", 32'h1, {31'h0, avs_waitrequest});
      @(posedge clk_sys);
      halt_mode <= 1'b0;
      i_sfowc_peer.select(1'b1);
      expect_reg("recovery", OFS_AUX, 8'h01);
      expect_reg("halt overrun", OFS_CSR, 8'hA0);
      expect_reg("halt byte", OFS_DATA, 8'h11);
   endtask

   task automatic run_ctl(input logic [7:0] ctl, input logic [7:0] d, input int exp_n);
      int n;
      n = 0;
      bus_write(OFS_CTRL, ctl);
      bus_write(OFS_DATA, d);
      check("data drive", 32'h1, {31'h0, mosi_oe});
      while (irq_req !== 1'b1 && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
      check("transfer cycles", exp_n, n);
      check("clock idle", {31'h0, ctl[CB_CPOL]}, {31'h0, sck_o});
      expect_reg("status sent", OFS_CSR, 8'h83);
      expect_reg("looped byte", OFS_DATA, d);
   endtask

   task automatic t_controller;
      avs_byteenable <= 4'h0;
      bus_write(OFS_CTRL, 8'hD0);
      avs_byteenable <= 4'hF;
      expect_reg("masked write", OFS_CTRL, 8'hC0);
      bus_write(OFS_CSR, 8'h03);
      run_ctl(8'hD0, 8'hA7, 16 * 2 * int'(MIN_HALF) + 1);
      expect_reg("recovery cleared", OFS_AUX, 8'h00);
      run_ctl(8'hFC, 8'h5A, 16 * int'(MIN_HALF) + 1);
   endtask

   task automatic conclude;
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset_values();
      t_mode_fault();
      t_fault();
      t_overrun();
      t_collision();
      t_halt();
      t_controller();
      conclude();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      conclude();
   end
endmodule // sfowc_bench
`default_nettype wire
